//--- design/tcv_vector.sv
// Purpose: capture/compare flags, prioritised vector and apb register file
// Assumes: counter runs elsewhere on pclk; cnt_tick marks each count step
// Notes: one wait state on every apb access; prdata is registered
`timescale 1ns/1ps
`default_nettype none
`include "tcv_regs.svh"
module tcv_vector
    import tcv_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // counter state
    input wire logic cnt_tick,
    input wire logic [15:0] cnt_value,
    input wire tcv_mode_t cnt_mode,
    input wire logic cnt_down,
    // capture pins
    input wire logic [`TCV_UNITS-1:0] cap_in_a,
    input wire logic [`TCV_UNITS-1:0] cap_in_b,
    // interrupts
    input wire logic irq_unit0_ack,
    output logic irq_unit0,
    output logic irq_shared,
    output logic irq
);
    localparam int NU = `TCV_UNITS;
    localparam int WRAP = NU; // flag index of the wrap source

    tcv_ctl_t ctl_r [NU];
    logic [15:0] ccr_r [NU];
    logic [NU:0] flag_r;
    logic [NU:0] flag_nxt;
    logic wrap_ie_r;
    logic [15:0] prev_cnt_r;
    tcv_state_t state_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_unit0_r;
    logic irq_shared_r;
    logic irq_r;
    logic [15:0] vec_latch_r;
    logic [2:0] vec_idx_r;
    logic vec_hit_r;

    logic [NU-1:0] cap_evt;
    logic [NU-1:0] cmp_evt;
    logic [NU-1:0] sel_level;
    logic [NU:0] hw_set;
    logic [NU:0] ie;
    logic [NU:0] pend;
    logic wrap_evt;
    logic [15:0] vec_code;
    logic [2:0] vec_idx;
    logic acc_done;
    logic wr_done;
    logic [ADDR_W-1:0] a;
    logic [31:0] rd_data;
    logic rd_err;

    // one unit per capture/compare channel
    for (genvar i = 0; i < NU; i++) begin : g_unit
        tcv_unit u_unit (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .in_a(cap_in_a[i]),
            .in_b(cap_in_b[i]),
            .ctl(ctl_r[i]),
            .cnt_tick(cnt_tick),
            .cnt_value(cnt_value),
            .ccr(ccr_r[i]),
            .sel_level(sel_level[i]),
            .cap_evt(cap_evt[i]),
            .cmp_evt(cmp_evt[i])
        );
        assign hw_set[i] = ce & (cap_evt[i] | cmp_evt[i]);
        assign ie[i] = ctl_r[i].ie;
    end

    // wrap to zero; the from-value depends on the counting mode
    always_comb begin
        wrap_evt = 1'b0;
        if (ce && cnt_tick && cnt_value == 16'h0000) begin
            case (cnt_mode)
                TCV_UP: wrap_evt = (prev_cnt_r == ccr_r[0]);
                TCV_CONT: wrap_evt = (prev_cnt_r == `TCV_WRAP_CONT);
                TCV_UPDOWN: wrap_evt = cnt_down &&
                    (prev_cnt_r == `TCV_WRAP_DOWN);
                default: wrap_evt = 1'b0;
            endcase
        end
    end
    assign hw_set[WRAP] = wrap_evt;
    assign ie[WRAP] = wrap_ie_r;

    // disabled flags still set but neither request nor show in the vector
    assign pend = flag_r & ie;

    // fixed priority encoder over the shared sources
    always_comb begin
        vec_code = `TCV_VEC_NONE;
        vec_idx = 3'h0;
        if (pend[1]) begin
            vec_code = `TCV_VEC_U1;
            vec_idx = 3'h1;
        end else if (pend[2]) begin
            vec_code = `TCV_VEC_U2;
            vec_idx = 3'h2;
        end else if (pend[3]) begin
            vec_code = `TCV_VEC_U3;
            vec_idx = 3'h3;
        end else if (pend[4]) begin
            vec_code = `TCV_VEC_U4;
            vec_idx = 3'h4;
        end else if (pend[WRAP]) begin
            vec_code = `TCV_VEC_WRAP;
            vec_idx = 3'(WRAP);
        end
    end

    assign a = paddr;
    assign acc_done = ce & psel & penable & pready_r;
    assign wr_done = acc_done & pwrite;

    // read mux and decode; misaligned or unknown addresses answer slverr
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (a[1:0] != 2'h0) begin
            rd_err = 1'b1;
        end else if (a[7:5] == 3'h0 && a[4:2] < 3'(NU)) begin
            rd_data[`TCV_FLAG_BIT] = flag_r[a[4:2]];
            rd_data[`TCV_INP_BIT] = sel_level[a[4:2]];
            rd_data[`TCV_IE_BIT] = ctl_r[a[4:2]].ie;
            rd_data[`TCV_CAP_BIT] = ctl_r[a[4:2]].cap;
            rd_data[`TCV_SEL_LO +: 2] = ctl_r[a[4:2]].in_sel;
            rd_data[`TCV_EDGE_LO +: 2] = ctl_r[a[4:2]].edge_sel;
        end else if (a[7:5] == 3'h1 && a[4:2] < 3'(NU)) begin
            rd_data[15:0] = ccr_r[a[4:2]];
        end else if (a == `TCV_TCTL_ADDR) begin
            rd_data[`TCV_WRAP_FLAG_BIT] = flag_r[WRAP];
            rd_data[`TCV_WRAP_IE_BIT] = wrap_ie_r;
        end else if (a == `TCV_VEC_ADDR) begin
            rd_data[15:0] = vec_code;
        end else if (a == `TCV_STAT_ADDR) begin
            rd_data[NU:0] = flag_r;
        end else if (a == `TCV_MASK_ADDR) begin
            rd_data[NU:0] = ie;
        end else begin
            rd_err = 1'b1;
        end
    end

    // apb handshake: latch answer and vector choice on the edge that raises pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= TCV_ST_IDLE;
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            vec_latch_r <= `TCV_VEC_NONE;
            vec_idx_r <= 3'h0;
            vec_hit_r <= 1'b0;
        end else if (ce) begin
            case (state_r)
                TCV_ST_IDLE: begin
                    if (psel && penable) begin
                        state_r <= TCV_ST_RESP;
                        pready_r <= 1'b1;
                        prdata_r <= pwrite ? 32'h0000_0000 : rd_data;
                        pslverr_r <= rd_err;
                        vec_latch_r <= vec_code;
                        vec_idx_r <= vec_idx;
                        vec_hit_r <= (a == `TCV_VEC_ADDR) &&
                                     (vec_code != `TCV_VEC_NONE);
                    end
                end
                TCV_ST_RESP: begin
                    state_r <= TCV_ST_IDLE;
                    pready_r <= 1'b0;
                    pslverr_r <= 1'b0;
                    vec_hit_r <= 1'b0;
                end
                default: begin
                    state_r <= TCV_ST_IDLE;
                    pready_r <= 1'b0;
                end
            endcase
        end
    end

    // flag update: hardware and software set win over every clear
    always_comb begin
        logic ctl_wr;
        logic clr;
        logic sw_set;
        ctl_wr = 1'b0;
        clr = 1'b0;
        sw_set = 1'b0;
        flag_nxt = flag_r;
        for (int i = 0; i <= NU; i++) begin
            if (i < NU) begin
                ctl_wr = wr_done && a[7:5] == 3'h0 && a[1:0] == 2'h0 &&
                         a[4:2] == 3'(i);
            end else begin
                ctl_wr = wr_done && a == `TCV_TCTL_ADDR;
            end
            sw_set = ctl_wr & pwdata[`TCV_FLAG_BIT];
            clr = (ctl_wr & ~pwdata[`TCV_FLAG_BIT]) |
                  (wr_done && a == `TCV_STAT_ADDR && pwdata[i]);
            // any completed vector access, read or write, clears the winner
            if (acc_done && vec_hit_r && vec_idx_r == 3'(i)) begin
                clr = 1'b1;
            end
            if (i == 0 && ce && irq_unit0_ack) begin
                clr = 1'b1;
            end
            flag_nxt[i] = hw_set[i] | sw_set | (flag_r[i] & ~clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= '0;
        end else if (ce) begin
            flag_r <= flag_nxt;
        end
    end

    // control, enable and compare registers; a capture beats a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NU; i++) begin
                ctl_r[i] <= `TCV_CTL_RST;
                ccr_r[i] <= `TCV_CCR_RST;
            end
            wrap_ie_r <= 1'b0;
        end else if (ce) begin
            for (int i = 0; i < NU; i++) begin
                if (wr_done && a[7:5] == 3'h0 && a[1:0] == 2'h0 &&
                    a[4:2] == 3'(i)) begin
                    ctl_r[i].edge_sel <= pwdata[`TCV_EDGE_LO +: 2];
                    ctl_r[i].in_sel <= pwdata[`TCV_SEL_LO +: 2];
                    ctl_r[i].cap <= pwdata[`TCV_CAP_BIT];
                    ctl_r[i].ie <= pwdata[`TCV_IE_BIT];
                end else if (wr_done && a == `TCV_MASK_ADDR) begin
                    ctl_r[i].ie <= pwdata[i];
                end
                if (cap_evt[i]) begin
                    ccr_r[i] <= cnt_value;
                end else if (wr_done && a[7:5] == 3'h1 && a[1:0] == 2'h0 &&
                             a[4:2] == 3'(i)) begin
                    ccr_r[i] <= pwdata[15:0];
                end
            end
            if (wr_done && a == `TCV_TCTL_ADDR) begin
                wrap_ie_r <= pwdata[`TCV_WRAP_IE_BIT];
            end else if (wr_done && a == `TCV_MASK_ADDR) begin
                wrap_ie_r <= pwdata[WRAP];
            end
        end
    end

    // previous counter value, sampled on each count step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_cnt_r <= 16'h0000;
        end else if (ce && cnt_tick) begin
            prev_cnt_r <= cnt_value;
        end
    end

    // requests; shared request yields to unit 0 so that unit 0 is served first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_unit0_r <= 1'b0;
            irq_shared_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_unit0_r <= pend[0];
            irq_shared_r <= (|pend[NU:1]) & ~pend[0];
            irq_r <= |pend;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq_unit0 = irq_unit0_r;
    assign irq_shared = irq_shared_r;
    assign irq = irq_r;

    a_vec_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (acc_done && !pwrite && a == `TCV_VEC_ADDR && vec_latch_r == 16'h0)
        |-> prdata == 32'h0)
        else $error("vector not zero with nothing pending");
    a_vec_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (acc_done && vec_hit_r && !hw_set[vec_idx_r])
        |=> !flag_r[$past(vec_idx_r)])
        else $error("vector access did not clear winner");
    a_vec_prio: assert property (@(posedge pclk) disable iff (!presetn)
        pend[1] |-> vec_code == 16'h0002)
        else $error("unit 1 not highest shared priority");
    a_u0_first: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && pend[0]) |=> (irq_unit0 && !irq_shared))
        else $error("unit 0 request not on top");
    a_dis_noirq: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && pend == '0) |=> (!irq && !irq_shared))
        else $error("request from disabled flag");
    a_u0_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && cmp_evt[0]) |=> flag_r[0])
        else $error("unit 0 compare did not set flag");
    a_wrap_set: assert property (@(posedge pclk) disable iff (!presetn)
        wrap_evt |=> flag_r[WRAP] ##1 1'b1)
        else $error("wrap did not set flag");
    a_u0_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && irq_unit0_ack && !hw_set[0] && !(wr_done && a == 8'h00))
        |=> !flag_r[0])
        else $error("unit 0 flag survived accept");
    a_shared_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !pend[0] && $countones(pend[NU:1]) > 1 && acc_done &&
         vec_hit_r)
        |=> ##1 (irq_shared || !ce || pend[0]))
        else $error("shared request dropped with flags left");

endmodule : tcv_vector
`default_nettype wire

//--- design/tcv_regs.svh
// Purpose: register offsets, field positions, reset values and vector codes
// Assumes: 32-bit apb data, byte addresses, one aligned word per register
// Notes: included by the vector block and the bench; holds definitions only
`ifndef TCV_REGS_SVH
`define TCV_REGS_SVH

`define TCV_UNITS 5
// register byte offsets
`define TCV_CTL_BASE 8'h00
`define TCV_CCR_BASE 8'h20
`define TCV_TCTL_ADDR 8'h40
`define TCV_VEC_ADDR 8'h44
`define TCV_STAT_ADDR 8'h48
`define TCV_MASK_ADDR 8'h4c
// control word field positions
`define TCV_FLAG_BIT 0
`define TCV_INP_BIT 3
`define TCV_IE_BIT 4
`define TCV_CAP_BIT 8
`define TCV_SEL_LO 12
`define TCV_EDGE_LO 14
// timer control field positions
`define TCV_WRAP_FLAG_BIT 0
`define TCV_WRAP_IE_BIT 1
// reset values
`define TCV_CTL_RST 6'h00
`define TCV_CCR_RST 16'h0000
// vector codes
`define TCV_VEC_NONE 16'h0000
`define TCV_VEC_U1 16'h0002
`define TCV_VEC_U2 16'h0004
`define TCV_VEC_U3 16'h0006
`define TCV_VEC_U4 16'h0008
`define TCV_VEC_WRAP 16'h000a
// wrap-from values
`define TCV_WRAP_CONT 16'hffff
`define TCV_WRAP_DOWN 16'h0001

`endif

//--- design/tcv_pkg.sv
// Purpose: shared types of the capture/compare vector block
// Assumes: constants come from tcv_regs.svh
// Notes: types only
package tcv_pkg;

    // stored control fields of one unit
    typedef struct packed {
        logic [1:0] edge_sel;
        logic [1:0] in_sel;
        logic cap;
        logic ie;
    } tcv_ctl_t;

    // counting modes of the outside counter
    typedef enum logic [1:0] {
        TCV_STOP = 2'h0,
        TCV_UP = 2'h1,
        TCV_CONT = 2'h2,
        TCV_UPDOWN = 2'h3
    } tcv_mode_t;

    // apb slave states, one-hot
    typedef enum logic [1:0] {
        TCV_ST_IDLE = 2'b01,
        TCV_ST_RESP = 2'b10
    } tcv_state_t;

endpackage : tcv_pkg

//--- design/tcv_unit.sv
// Purpose: input select, synchroniser and edge/compare detect of one unit
// Assumes: inputs a and b come from pins, the rest from pclk logic
// Notes: events are combinational and only valid while ce is high
`timescale 1ns/1ps
`default_nettype none
module tcv_unit
    import tcv_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // pins
    input wire logic in_a,
    input wire logic in_b,
    // configuration
    input wire tcv_ctl_t ctl,
    // counter
    input wire logic cnt_tick,
    input wire logic [15:0] cnt_value,
    input wire logic [15:0] ccr,
    // events
    output logic sel_level,
    output logic cap_evt,
    output logic cmp_evt
);
    logic [1:0] a_sync_r;
    logic [1:0] b_sync_r;
    logic prev_r;
    logic rise;
    logic fall;

    // two flops per pin; only the second stage is looked at
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_sync_r <= 2'h0;
            b_sync_r <= 2'h0;
        end else if (ce) begin
            a_sync_r <= {a_sync_r[0], in_a};
            b_sync_r <= {b_sync_r[0], in_b};
        end
    end

    // source mux; the constant levels let software make its own edge
    always_comb begin
        case (ctl.in_sel)
            2'h0: sel_level = a_sync_r[1];
            2'h1: sel_level = b_sync_r[1];
            2'h2: sel_level = 1'b0;
            default: sel_level = 1'b1;
        endcase
    end

    // previous selected level for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 1'b0;
        end else if (ce) begin
            prev_r <= sel_level;
        end
    end

    assign rise = sel_level & ~prev_r;
    assign fall = ~sel_level & prev_r;
    // select and edge fields matter to cap_evt only in capture operation; sel_level always follows select
    assign cap_evt = ctl.cap & ((ctl.edge_sel[0] & rise) |
                                (ctl.edge_sel[1] & fall));
    assign cmp_evt = ~ctl.cap & cnt_tick & (cnt_value == ccr);

    a_edge_off: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl.edge_sel == 2'h0) |-> !cap_evt)
        else $error("capture with edge field off");
    a_cmp_nocap: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctl.cap && $changed(sel_level)) |-> !cap_evt)
        else $error("capture event in compare operation");
    a_sel_const: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl.in_sel == 2'h3) |-> sel_level)
        else $error("select 3 not high");

endmodule : tcv_unit
`default_nettype wire

//--- verification/tcv_cpu_model.sv
// Purpose: cpu side model that accepts the unit 0 interrupt request
// Assumes: accept pulse lasts one pclk cycle
// Notes: accepts once per request, then waits for the request to drop
`timescale 1ns/1ps
`default_nettype none
module tcv_cpu_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request and accept
    input wire logic ack_en,
    input wire logic irq_unit0,
    output logic irq_unit0_ack
);
    logic busy_r;

    // the request drops two edges after the pulse, so hold off meanwhile
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_unit0_ack <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            irq_unit0_ack <= ack_en && irq_unit0 && !busy_r;
            busy_r <= irq_unit0 && (busy_r || ack_en);
        end
    end
endmodule : tcv_cpu_model
`default_nettype wire

//--- verification/test_timer_capture_irq_vector.sv
// Purpose: self-checking bench of the capture/compare vector block
// Assumes: apb answers with one wait state; all readable registers reset to zero
// Notes: register offsets and codes come from tcv_regs.svh
`timescale 1ns/1ps
`default_nettype none
`include "tcv_regs.svh"
module test_timer_capture_irq_vector;
    import tcv_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cnt_tick, cnt_down, ack_en, ack, irq_unit0, irq_shared, irq, er;
    logic [15:0] cnt_value;
    tcv_mode_t cnt_mode;
    logic [4:0] cap_in_a, cap_in_b;
    int err_count = 0;
    int n_compared = 0;

    tcv_vector #(.ADDR_W(8)) u_tcv_vector (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cnt_tick(cnt_tick), .cnt_value(cnt_value),
        .cnt_mode(cnt_mode), .cnt_down(cnt_down), .cap_in_a(cap_in_a),
        .cap_in_b(cap_in_b), .irq_unit0_ack(ack), .irq_unit0(irq_unit0),
        .irq_shared(irq_shared), .irq(irq));
    tcv_cpu_model u_tcv_cpu_model (.pclk(pclk), .presetn(presetn),
        .ack_en(ack_en), .irq_unit0(irq_unit0), .irq_unit0_ack(ack));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            err_count++;
            tally_and_finish();
        end
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic step(input logic [15:0] v);
        @(posedge pclk);
        cnt_value <= v;
        cnt_tick <= 1'b1;
        @(posedge pclk);
        cnt_tick <= 1'b0;
    endtask : step

    // reset values and an unmapped address
    task automatic t_reset();
        rdchk(`TCV_CTL_BASE, 32'h0);
        rdchk(`TCV_MASK_ADDR, 32'h0);
        rdchk(`TCV_VEC_ADDR, 32'h0);
        apb(1'b0, 8'h50, 32'h0);
        chk({31'h0, er}, 32'h1);
    endtask : t_reset

    // service reads only; the vector is never written here
    task automatic t_vector_read();
        apb(1'b1, `TCV_CTL_BASE + 8'h08, 32'h11);
        apb(1'b1, `TCV_CTL_BASE + 8'h0c, 32'h11);
        apb(1'b1, `TCV_MASK_ADDR, 32'h0);
        tick(2);
        chk({31'h0, irq_shared}, 32'h0);
        apb(1'b1, `TCV_MASK_ADDR, 32'h0c);
        tick(2);
        chk({31'h0, irq_shared}, 32'h1);
        rdchk(`TCV_VEC_ADDR, {16'h0, `TCV_VEC_U2});
        tick(2);
        chk({31'h0, irq_shared}, 32'h1);
        rdchk(`TCV_VEC_ADDR, {16'h0, `TCV_VEC_U3});
        rdchk(`TCV_VEC_ADDR, 32'h0);
        tick(2);
        chk({31'h0, irq_shared}, 32'h0);
    endtask : t_vector_read

    // a write consumes the winner, the rest keep their order
    task automatic t_vector_write();
        apb(1'b1, `TCV_CTL_BASE + 8'h04, 32'h11);
        apb(1'b1, `TCV_CTL_BASE + 8'h10, 32'h11);
        apb(1'b1, `TCV_TCTL_ADDR, 32'h3);
        apb(1'b1, `TCV_VEC_ADDR, 32'h0);
        rdchk(`TCV_VEC_ADDR, {16'h0, `TCV_VEC_U4});
        rdchk(`TCV_VEC_ADDR, {16'h0, `TCV_VEC_WRAP});
        rdchk(`TCV_VEC_ADDR, 32'h0);
    endtask : t_vector_write

    // a flag with its enable clear is neither reported nor cleared
    task automatic t_disabled();
        apb(1'b1, `TCV_CTL_BASE + 8'h04, 32'h01);
        rdchk(`TCV_VEC_ADDR, 32'h0);
        rdchk(`TCV_CTL_BASE + 8'h04, 32'h01);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `TCV_CTL_BASE + 8'h04, 32'h0);
    endtask : t_disabled

    // unit 0 request outranks the shared one and clears on accept
    task automatic t_unit0();
        int i;
        apb(1'b1, `TCV_CTL_BASE + 8'h08, 32'h11);
        apb(1'b1, `TCV_CTL_BASE, 32'h11);
        tick(2);
        chk({29'h0, irq_unit0, irq_shared, irq}, 32'h5);
        ack_en <= 1'b1;
        for (i = 0; i < 10 && irq_unit0 !== 1'b0; i++) tick(1);
        ack_en <= 1'b0;
        chk({31'h0, irq_unit0}, 32'h0);
        tick(1);
        chk({31'h0, irq_shared}, 32'h1);
        rdchk(`TCV_CTL_BASE, 32'h10);
        rdchk(`TCV_VEC_ADDR, {16'h0, `TCV_VEC_U2});
    endtask : t_unit0

    // compare match on unit 0 and wrap from ffff in continuous mode
    task automatic t_count();
        apb(1'b1, `TCV_CCR_BASE, 32'h5);
        apb(1'b1, `TCV_STAT_ADDR, 32'h3f);
        step(16'h0005);
        tick(1);
        rdchk(`TCV_STAT_ADDR, 32'h01);
        cnt_mode <= TCV_CONT;
        step(16'hffff);
        step(16'h0000);
        tick(1);
        apb(1'b0, `TCV_STAT_ADDR, 32'h0);
        chk({31'h0, rd[5]}, 32'h1);
        apb(1'b1, `TCV_STAT_ADDR, 32'h3f);
        rdchk(`TCV_STAT_ADDR, 32'h0);
        // up mode wraps from the unit 0 value, up/down from 0001 going down
        for (int m = 0; m < 2; m++) begin
            cnt_mode <= (m == 1) ? TCV_UPDOWN : TCV_UP;
            cnt_down <= (m == 1);
            step((m == 1) ? `TCV_WRAP_DOWN : 16'h0005);
            step(16'h0000);
            tick(1);
            apb(1'b0, `TCV_STAT_ADDR, 32'h0);
            chk({31'h0, rd[5]}, 32'h1);
            apb(1'b1, `TCV_STAT_ADDR, 32'h3f);
        end
    endtask : t_count

    // input select levels first; in the edge checks capture mode is set before the pin edge arrives
    task automatic t_capture();
        logic [31:0] w;
        for (int s = 0; s < 4; s++) begin
            cap_in_a <= 5'h02;
            cap_in_b <= 5'h00;
            apb(1'b1, `TCV_CTL_BASE + 8'h04, 32'h100 | (s << 12));
            tick(4);
            apb(1'b0, `TCV_CTL_BASE + 8'h04, 32'h0);
            chk({31'h0, rd[3]}, {31'h0, (s == 0 || s == 3)});
        end
        for (int e = 0; e < 4; e++) begin
            w = 32'h100 | (e << 14);
            cap_in_a <= 5'h00;
            apb(1'b1, `TCV_CTL_BASE + 8'h04, w);
            cap_in_a <= 5'h02;
            tick(5);
            apb(1'b0, `TCV_CTL_BASE + 8'h04, 32'h0);
            chk({31'h0, rd[0]}, e & 1);
            apb(1'b1, `TCV_CTL_BASE + 8'h04, w);
            cap_in_a <= 5'h00;
            tick(5);
            apb(1'b0, `TCV_CTL_BASE + 8'h04, 32'h0);
            chk({31'h0, rd[0]}, (e >> 1) & 1);
        end
    endtask : t_capture

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cnt_tick = 1'b0;
        cnt_value = 16'h0000;
        cnt_mode = TCV_STOP;
        cnt_down = 1'b0;
        cap_in_a = 5'h00;
        cap_in_b = 5'h00;
        ack_en = 1'b0;
        tick(12);
        presetn <= 1'b1;
        t_reset();
        t_vector_read();
        t_vector_write();
        t_disabled();
        t_unit0();
        t_count();
        t_capture();
        tally_and_finish();
    end
endmodule : test_timer_capture_irq_vector
`default_nettype wire
